// File: verification/cdio_far_model.sv
`timescale 1ns/10ps
module cdio_far_model (
  input wire logic aclk,
  input wire logic [7:0] lines_out,
  input wire logic [7:0] lines_oe,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] lines_in,
  output logic gen_valid,
  input wire logic gen_ready,
  output logic [7:0] gen_data,
  input wire logic acq_valid,
  output logic acq_ready,
  input wire logic [7:0] acq_data,
  input wire logic acq_stall
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  // weak pull-up: a line nobody drives reads high
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lines_in[i] = lines_oe[i] ? lines_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
  initial begin
    gen_valid = 1'b0;
    gen_data = 8'h00;
    acq_ready = 1'b0;
  end
  always @(posedge aclk) begin
    if (gen_valid && gen_ready) begin
      send_q.delete(0);
    end
    gen_valid <= (send_q.size() != 0);
    // idle data toggles so a stale word never looks valid
    gen_data <= (send_q.size() != 0) ? send_q[0] : ~gen_data;
    if (acq_valid && acq_ready) begin
      got_q.push_back(acq_data);
    end
    acq_ready <= !acq_stall;
  end
endmodule

// File: verification/cdio_props.sv
`timescale 1ns/10ps
module cdio_props #(
  parameter int LINES = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [LINES-1:0] port_lines_in,
  input wire logic [LINES-1:0] port_lines_oe,
  input wire logic counter0_up_down,
  input wire logic counter1_up_down,
  input wire logic gen_dma_ready,
  input wire logic acq_dma_valid,
  input wire logic acq_dma_ready,
  input wire logic [LINES-1:0] acq_dma_data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence l6_quiet;
    $stable(port_lines_in[6]) [*5];
  endsequence
  sequence l7_quiet;
    $stable(port_lines_in[7]) [*5];
  endsequence
  // reset must be seen, so this one is not disabled by it
  chk_reset_undriven: assert property (disable iff (1'b0) !aresetn |=>
    port_lines_oe == '0 && gen_dma_ready && !acq_dma_valid) else $error("lines driven in reset");
  chk_ctr0_dir: assert property (l6_quiet |-> counter0_up_down == port_lines_in[6])
    else $error("counter 0 direction wrong");
  chk_ctr1_dir: assert property (l7_quiet |-> counter1_up_down == port_lines_in[7])
    else $error("counter 1 direction wrong");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_read_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
  chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_oe_sw_only: assert property ($changed(port_lines_oe) |-> $past(s_axi_bvalid))
    else $error("direction changed without access");
  chk_acq_hold: assert property (acq_dma_valid && !acq_dma_ready |=>
    acq_dma_valid && $stable(acq_dma_data)) else $error("acquired word dropped");
endmodule
bind correlated_digital_io_port cdio_props #(.LINES(LINES)) chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .port_lines_in(port_lines_in), .port_lines_oe(port_lines_oe),
  .counter0_up_down(counter0_up_down), .counter1_up_down(counter1_up_down),
  .gen_dma_ready(gen_dma_ready), .acq_dma_valid(acq_dma_valid), .acq_dma_ready(acq_dma_ready),
  .acq_dma_data(acq_dma_data));

// File: verification/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} row_t;
  logic aclk, aresetn, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdt, rd;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] p_in, p_out, p_oe, ext_en, ext_val, g_d, a_d;
  logic [9:0] sclk;
  logic c0, c1, g_v, g_r, a_v, a_r, stall;
  logic [7:0] smp[3] = '{8'h3c, 8'hc3, 8'h5a};
  row_t rows[6];
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  correlated_digital_io_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .port_lines_in(p_in), .port_lines_out(p_out), .port_lines_oe(p_oe), .analog_in_sample_clock(sclk[0]),
    .analog_out_sample_clock(sclk[1]), .counter0_out(sclk[2]), .trigger_bus_lines(sclk[9:3]),
    .counter0_up_down(c0), .counter1_up_down(c1), .gen_dma_valid(g_v), .gen_dma_ready(g_r),
    .gen_dma_data(g_d), .acq_dma_valid(a_v), .acq_dma_ready(a_r), .acq_dma_data(a_d));
  cdio_far_model far_u (.aclk(aclk), .lines_out(p_out), .lines_oe(p_oe), .ext_en(ext_en), .ext_val(ext_val),
    .lines_in(p_in), .gen_valid(g_v), .gen_ready(g_r), .gen_data(g_d), .acq_valid(a_v), .acq_ready(a_r),
    .acq_data(a_d), .acq_stall(stall));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic finish_test();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_r(input logic [1:0] g, input logic [1:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t resp=%h exp=%h", $time, g, e);
    end
  endtask
  // bready comes late on purpose so the response must be held
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_open, w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    forever begin
      @(posedge aclk);
      if (aw_open && awr) begin
        aw_open = 1'b0;
        awv <= 1'b0;
      end
      if (w_open && wr_rdy) begin
        w_open = 1'b0;
        wv <= 1'b0;
      end
      if (bv && br) begin
        r = bresp;
        br <= 1'b0;
        break;
      end
      if (bv) br <= 1'b1;
    end
  endtask
  task automatic rd_(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
      if (rv && rr) begin
        d = rdt;
        r = rresp;
        rr <= 1'b0;
        break;
      end
      if (rv) rr <= 1'b1;
    end
  endtask
  // 49.3 ns period, off the core clock's phase; sources keep edges far apart
  task automatic pulse(input int k);
    #1.3;
    sclk[k] = 1'b1;
    #24;
    sclk[k] = 1'b0;
    #24;
  endtask
  initial begin
    {aresetn, awv, wv, br, arv, rr, stall} = '0;
    {awa, ara, wd, sclk} = '0;
    ws = 4'hf;
    ext_en = 8'h0f;
    ext_val = 8'h03;
    rows = '{'{12'h000, 32'hf0, 32'hf0, 2'b00}, '{12'h004, 32'h00, 32'h00, 2'b00},
      '{12'h008, 32'ha5, 32'ha5, 2'b00}, '{12'h010, 32'h1b, 32'h1b, 2'b00},
      '{12'h014, 32'h12, 32'h12, 2'b00}, '{12'h020, 32'h55, 32'h00, 2'b10}};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_w(32'(p_oe), 32'h0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rs);
      cmp_r(rs, rows[i].r);
      rd_(rows[i].a, rd, rs);
      cmp_r(rs, rows[i].r);
      if (rows[i].r == 2'b00) cmp_w(rd, rows[i].e);
    end
    repeat (6) @(posedge aclk);
    cmp_w(32'(p_oe), 32'hf0);
    cmp_w(32'(p_out & p_oe), 32'ha0);
    rd_(12'h00c, rd, rs);
    cmp_w(rd, 32'ha3);
    rd_(12'h01c, rd, rs);
    cmp_w(rd, 32'h2);
    cmp_w(32'({c1, c0}), 32'h2);
    wr(12'h004, 32'hff, rs);
    wr(12'h000, 32'hff, rs);
    wr(12'h010, 32'h10b, rs);
    foreach (smp[i]) far_u.send_q.push_back(smp[i]);
    repeat (10) @(posedge aclk);
    foreach (smp[i]) begin
      pulse(6);
      repeat (8) @(posedge aclk);
      cmp_w(32'(p_out), 32'(smp[i]));
    end
    pulse(6);
    repeat (8) @(posedge aclk);
    rd_(12'h018, rd, rs);
    cmp_w(rd, 32'h5);
    rd_(12'h018, rd, rs);
    cmp_w(rd, 32'h5);
    wr(12'h018, 32'h1, rs);
    rd_(12'h018, rd, rs);
    cmp_w(rd, 32'h4);
    wr(12'h010, 32'h0, rs);
    wr(12'h000, 32'h0, rs);
    ext_en <= 8'hff;
    for (int k = 0; k < 10; k++) begin
      ext_val <= 8'(k * 8'h1d + 8'h01);
      wr(12'h014, 32'(32'h110 + ((k < 3) ? k : k + 5)), rs);
      repeat (8) @(posedge aclk);
      n = far_u.got_q.size();
      pulse(k);
      repeat (12) @(posedge aclk);
      cmp_w(32'(far_u.got_q.size()), 32'(n + 1));
      cmp_w(32'(far_u.got_q[$]), 32'(8'(k * 8'h1d + 8'h01)));
    end
    stall <= 1'b1;
    wr(12'h014, 32'h118, rs);
    repeat (8) @(posedge aclk);
    n = far_u.got_q.size();
    repeat (17) pulse(3);
    repeat (8) @(posedge aclk);
    rd_(12'h018, rd, rs);
    cmp_w(rd, 32'he);
    stall <= 1'b0;
    repeat (40) @(posedge aclk);
    cmp_w(32'(far_u.got_q.size()), 32'(n + 16));
    wr(12'h018, 32'h2, rs);
    rd_(12'h018, rd, rs);
    cmp_w(rd, 32'h4);
    wr(12'h000, 32'hff, rs);
    repeat (3) @(posedge aclk);
    cmp_w(32'(p_oe), 32'hff);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    cmp_w(32'(p_oe), 32'h0);
    cmp_w(32'(g_r), 32'h1);
    finish_test();
  end
endmodule

// File: verilog/cdio_map.svh
`ifndef CDIO_MAP_SVH
`define CDIO_MAP_SVH

// register byte offsets
`define CDIO_DIR_OFFSET 12'h000
`define CDIO_FUNC_OFFSET 12'h004
`define CDIO_STATIC_OUT_OFFSET 12'h008
`define CDIO_PIN_STATE_OFFSET 12'h00c
`define CDIO_GEN_CLK_OFFSET 12'h010
`define CDIO_ACQ_CLK_OFFSET 12'h014
`define CDIO_STATUS_OFFSET 12'h018
`define CDIO_COUNTER_DIR_OFFSET 12'h01c

// sample clock config fields
`define CDIO_CLK_SRC_LSB 0
`define CDIO_CLK_SRC_MSB 3
`define CDIO_CLK_FALLING_BIT 4
`define CDIO_CLK_ENABLE_BIT 8

// status fields
`define CDIO_STAT_UNDERFLOW_BIT 0
`define CDIO_STAT_OVERFLOW_BIT 1
`define CDIO_STAT_GEN_EMPTY_BIT 2
`define CDIO_STAT_ACQ_FULL_BIT 3

// reset values
`define CDIO_DIR_RESET 8'h00
`define CDIO_FUNC_RESET 8'h00
`define CDIO_STATIC_OUT_RESET 8'h00
`define CDIO_CLK_CFG_RESET 32'h0000_0000

// timing counts
`define CDIO_SYNC_STAGES 2
`define CDIO_FIFO_DEPTH 16

// axi responses
`define CDIO_RESP_OKAY 2'b00
`define CDIO_RESP_SLVERR 2'b10

`endif

// File: verilog/cdio_pkg.sv
package cdio_pkg;

  typedef enum logic [3:0] {
    src_analog_in = 4'h0,
    src_analog_out = 4'h1,
    src_counter0_out = 4'h2,
    src_trigger0 = 4'h8,
    src_trigger1 = 4'h9,
    src_trigger2 = 4'ha,
    src_trigger3 = 4'hb,
    src_trigger4 = 4'hc,
    src_trigger5 = 4'hd,
    src_trigger6 = 4'he
  } clk_src_t;

  typedef enum logic [2:0] {
    wr_idle = 3'b001,
    wr_collect = 3'b010,
    wr_respond = 3'b100
  } wr_state_t;

endpackage

// File: verilog/correlated_digital_io_port.sv
`timescale 1ns/10ps
`include "cdio_map.svh"
// Contract
// - eight bidirectional lines with own controls
// - each line input or output independently
// - static reads and writes happen on access
// - lines 6,7 feed counter directions
// - line may be waveform generation output
// - generation samples held in DMA-fed FIFO
// - active output clock edge pops and drives
// - output edge on empty FIFO flags underflow
// - output clock from ai, ao, counter0
// - output clock from trigger lines 0..6
// - line may be waveform acquisition input
// - active input clock edge captures all lines
// - input FIFO drained to memory by DMA
// - input edge on full FIFO flags overflow
// - input clock from ai, ao, counter0
// - input clock from trigger lines 0..6
// - reset leaves all lines undriven inputs
module correlated_digital_io_port #(
  parameter int LINES = 8,
  parameter int FIFO_DEPTH = `CDIO_FIFO_DEPTH,
  parameter bit HAS_ANALOG_OUT_CLOCK = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [LINES-1:0] port_lines_in,
  output logic [LINES-1:0] port_lines_out,
  output logic [LINES-1:0] port_lines_oe,
  input wire logic analog_in_sample_clock,
  input wire logic analog_out_sample_clock,
  input wire logic counter0_out,
  input wire logic [6:0] trigger_bus_lines,
  output logic counter0_up_down,
  output logic counter1_up_down,
  input wire logic gen_dma_valid,
  output logic gen_dma_ready,
  input wire logic [LINES-1:0] gen_dma_data,
  output logic acq_dma_valid,
  input wire logic acq_dma_ready,
  output logic [LINES-1:0] acq_dma_data
);
  initial begin
    if (LINES != 8) begin
      $error("correlated_digital_io_port supports exactly eight lines");
    end
  end

  // software registers, status flags and the waveform output register
  logic [LINES-1:0] dir_reg;
  logic [LINES-1:0] func_reg;
  logic [LINES-1:0] static_out_reg;
  logic [31:0] gen_clk_reg;
  logic [31:0] acq_clk_reg;
  logic underflow_reg;
  logic overflow_reg;
  logic [LINES-1:0] wave_out_reg;

  // pin synchroniser
  logic [LINES-1:0] pin_meta_reg;
  logic [LINES-1:0] pin_sync_reg;

  // write channel state
  cdio_pkg::wr_state_t wr_state_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0] wr_strb_reg;
  logic wr_fire;
  logic wr_hit;
  logic clr_underflow;
  logic clr_overflow;

  // sample path wiring
  logic gen_edge;
  logic acq_edge;
  logic gen_fifo_valid;
  logic [LINES-1:0] gen_fifo_data;
  logic gen_pop;
  logic acq_fifo_ready;
  logic acq_push;
  logic [LINES-1:0] port_lines_out_next;

  // merge the enabled byte lanes of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= port_lines_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // AXI4-Lite write: address and data taken in either order
  assign wr_fire = (wr_state_reg == cdio_pkg::wr_collect) && aw_held_reg && w_held_reg;

  always_comb begin
    case (wr_addr_reg)
      `CDIO_DIR_OFFSET, `CDIO_FUNC_OFFSET, `CDIO_STATIC_OUT_OFFSET, `CDIO_GEN_CLK_OFFSET,
      `CDIO_ACQ_CLK_OFFSET, `CDIO_STATUS_OFFSET: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= cdio_pkg::wr_idle;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      wr_strb_reg <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CDIO_RESP_OKAY;
    end else begin
      case (wr_state_reg)
        cdio_pkg::wr_idle: begin
          aw_held_reg <= 1'b0;
          w_held_reg <= 1'b0;
          s_axi_awready <= 1'b1;
          s_axi_wready <= 1'b1;
          wr_state_reg <= cdio_pkg::wr_collect;
        end
        cdio_pkg::wr_collect: begin
          if (s_axi_awvalid && s_axi_awready) begin
            wr_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
            aw_held_reg <= 1'b1;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            wr_data_reg <= s_axi_wdata;
            wr_strb_reg <= s_axi_wstrb;
            w_held_reg <= 1'b1;
            s_axi_wready <= 1'b0;
          end
          if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `CDIO_RESP_OKAY : `CDIO_RESP_SLVERR;
            wr_state_reg <= cdio_pkg::wr_respond;
          end
        end
        cdio_pkg::wr_respond: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_reg <= cdio_pkg::wr_idle;
          end
        end
        default: wr_state_reg <= cdio_pkg::wr_idle;
      endcase
    end
  end

  // control registers; reset leaves every line an undriven input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_reg <= `CDIO_DIR_RESET;
      func_reg <= `CDIO_FUNC_RESET;
      static_out_reg <= `CDIO_STATIC_OUT_RESET;
      gen_clk_reg <= `CDIO_CLK_CFG_RESET;
      acq_clk_reg <= `CDIO_CLK_CFG_RESET;
    end else if (wr_fire) begin
      case (wr_addr_reg)
        `CDIO_DIR_OFFSET: dir_reg <= LINES'(merge({24'h0, dir_reg}, wr_data_reg, wr_strb_reg));
        `CDIO_FUNC_OFFSET: func_reg <= LINES'(merge({24'h0, func_reg}, wr_data_reg, wr_strb_reg));
        `CDIO_STATIC_OUT_OFFSET: static_out_reg <= LINES'(merge({24'h0, static_out_reg}, wr_data_reg, wr_strb_reg));
        `CDIO_GEN_CLK_OFFSET: gen_clk_reg <= merge(gen_clk_reg, wr_data_reg, wr_strb_reg);
        `CDIO_ACQ_CLK_OFFSET: acq_clk_reg <= merge(acq_clk_reg, wr_data_reg, wr_strb_reg);
        default: ;
      endcase
    end
  end

  // write-one-to-clear on the status word
  assign clr_underflow = wr_fire && (wr_addr_reg == `CDIO_STATUS_OFFSET) && wr_strb_reg[0]
                         && wr_data_reg[`CDIO_STAT_UNDERFLOW_BIT];
  assign clr_overflow = wr_fire && (wr_addr_reg == `CDIO_STATUS_OFFSET) && wr_strb_reg[0]
                        && wr_data_reg[`CDIO_STAT_OVERFLOW_BIT];

  // AXI4-Lite read: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CDIO_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CDIO_RESP_OKAY;
        s_axi_rdata <= '0;
        case ({s_axi_araddr[11:2], 2'b00})
          `CDIO_DIR_OFFSET: s_axi_rdata <= {24'h0, dir_reg};
          `CDIO_FUNC_OFFSET: s_axi_rdata <= {24'h0, func_reg};
          `CDIO_STATIC_OUT_OFFSET: s_axi_rdata <= {24'h0, static_out_reg};
          `CDIO_PIN_STATE_OFFSET: s_axi_rdata <= {24'h0, pin_sync_reg};
          `CDIO_GEN_CLK_OFFSET: s_axi_rdata <= gen_clk_reg;
          `CDIO_ACQ_CLK_OFFSET: s_axi_rdata <= acq_clk_reg;
          `CDIO_STATUS_OFFSET: begin
            s_axi_rdata[`CDIO_STAT_UNDERFLOW_BIT] <= underflow_reg;
            s_axi_rdata[`CDIO_STAT_OVERFLOW_BIT] <= overflow_reg;
            s_axi_rdata[`CDIO_STAT_GEN_EMPTY_BIT] <= !gen_fifo_valid;
            s_axi_rdata[`CDIO_STAT_ACQ_FULL_BIT] <= !acq_fifo_ready;
          end
          `CDIO_COUNTER_DIR_OFFSET: s_axi_rdata <= {30'h0, counter1_up_down, counter0_up_down};
          default: s_axi_rresp <= `CDIO_RESP_SLVERR;
        endcase
      end
    end
  end

  // generation path
  sample_clock_select u_gen_clk (
    .clk(aclk),
    .rst_n(aresetn),
    .analog_in_sample_clock(analog_in_sample_clock),
    .analog_out_sample_clock(HAS_ANALOG_OUT_CLOCK ? analog_out_sample_clock : 1'b0),
    .counter0_out(counter0_out),
    .trigger_bus_lines(trigger_bus_lines),
    .source(gen_clk_reg[`CDIO_CLK_SRC_MSB:`CDIO_CLK_SRC_LSB]),
    .falling(gen_clk_reg[`CDIO_CLK_FALLING_BIT]),
    .enable(gen_clk_reg[`CDIO_CLK_ENABLE_BIT]),
    .edge_pulse(gen_edge)
  );

  // refill from host memory, stalled by a full FIFO
  sample_fifo #(.WIDTH(LINES), .DEPTH(FIFO_DEPTH)) u_gen_fifo (
    .clk(aclk),
    .rst_n(aresetn),
    .in_valid(gen_dma_valid),
    .in_ready(gen_dma_ready),
    .in_data(gen_dma_data),
    .out_valid(gen_fifo_valid),
    .out_ready(gen_pop),
    .out_data(gen_fifo_data)
  );

  // relies on the clock source spacing edges by at least two cycles
  assign gen_pop = gen_edge && gen_fifo_valid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_out_reg <= '0;
    end else if (gen_pop) begin
      wave_out_reg <= gen_fifo_data;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      underflow_reg <= 1'b0;
    end else if (gen_edge && !gen_fifo_valid) begin
      underflow_reg <= 1'b1;
    end else if (clr_underflow) begin
      underflow_reg <= 1'b0;
    end
  end

  // acquisition path
  sample_clock_select u_acq_clk (
    .clk(aclk),
    .rst_n(aresetn),
    .analog_in_sample_clock(analog_in_sample_clock),
    .analog_out_sample_clock(HAS_ANALOG_OUT_CLOCK ? analog_out_sample_clock : 1'b0),
    .counter0_out(counter0_out),
    .trigger_bus_lines(trigger_bus_lines),
    .source(acq_clk_reg[`CDIO_CLK_SRC_MSB:`CDIO_CLK_SRC_LSB]),
    .falling(acq_clk_reg[`CDIO_CLK_FALLING_BIT]),
    .enable(acq_clk_reg[`CDIO_CLK_ENABLE_BIT]),
    .edge_pulse(acq_edge)
  );

  // a full FIFO drops the sample rather than overwrite older data
  assign acq_push = acq_edge && acq_fifo_ready;

  // all eight lines are captured whatever their direction
  sample_fifo #(.WIDTH(LINES), .DEPTH(FIFO_DEPTH)) u_acq_fifo (
    .clk(aclk),
    .rst_n(aresetn),
    .in_valid(acq_push),
    .in_ready(acq_fifo_ready),
    .in_data(pin_sync_reg),
    .out_valid(acq_dma_valid),
    .out_ready(acq_dma_ready),
    .out_data(acq_dma_data)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_reg <= 1'b0;
    end else if (acq_edge && !acq_fifo_ready) begin
      overflow_reg <= 1'b1;
    end else if (clr_overflow) begin
      overflow_reg <= 1'b0;
    end
  end

  // pin drivers: direction per line, source per line
  for (genvar i = 0; i < LINES; i++) begin : g_line
    assign port_lines_out_next[i] = func_reg[i] ? wave_out_reg[i] : static_out_reg[i];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_lines_out <= '0;
      port_lines_oe <= '0;
    end else begin
      port_lines_out <= port_lines_out_next;
      port_lines_oe <= dir_reg;
    end
  end

  // count direction taps; they never change the line's own function
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter0_up_down <= 1'b0;
      counter1_up_down <= 1'b0;
    end else begin
      counter0_up_down <= pin_sync_reg[6];
      counter1_up_down <= pin_sync_reg[7];
    end
  end
endmodule

// File: verilog/sample_clock_select.sv
`timescale 1ns/10ps
module sample_clock_select (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic analog_in_sample_clock,
  input wire logic analog_out_sample_clock,
  input wire logic counter0_out,
  input wire logic [6:0] trigger_bus_lines,
  input wire logic [3:0] source,
  input wire logic falling,
  input wire logic enable,
  output logic edge_pulse
);
  // sources: 0 ai, 1 ao, 2 counter 0, 3..9 trigger lines 0..6
  localparam int NSRC = 10;
  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] meta_reg;
  logic [NSRC-1:0] sync_reg;
  logic sel;
  logic prev_reg;
  logic prev_valid_reg;

  assign raw = {trigger_bus_lines, counter0_out, analog_out_sample_clock, analog_in_sample_clock};

  for (genvar i = 0; i < NSRC; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        meta_reg[i] <= 1'b0;
        sync_reg[i] <= 1'b0;
      end else begin
        meta_reg[i] <= raw[i];
        sync_reg[i] <= meta_reg[i];
      end
    end
  end

  always_comb begin
    case (source)
      cdio_pkg::src_analog_in: sel = sync_reg[0];
      cdio_pkg::src_analog_out: sel = sync_reg[1];
      cdio_pkg::src_counter0_out: sel = sync_reg[2];
      cdio_pkg::src_trigger0: sel = sync_reg[3];
      cdio_pkg::src_trigger1: sel = sync_reg[4];
      cdio_pkg::src_trigger2: sel = sync_reg[5];
      cdio_pkg::src_trigger3: sel = sync_reg[6];
      cdio_pkg::src_trigger4: sel = sync_reg[7];
      cdio_pkg::src_trigger5: sel = sync_reg[8];
      cdio_pkg::src_trigger6: sel = sync_reg[9];
      default: sel = 1'b0;
    endcase
  end

  // polarity folded in before edge detect so falling becomes rising
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
      prev_valid_reg <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      prev_reg <= sel ^ falling;
      // first cycle after enable only primes, so a stale level is no edge
      prev_valid_reg <= enable;
      edge_pulse <= enable && prev_valid_reg && (sel ^ falling) && !prev_reg;
    end
  end
endmodule

// File: verilog/sample_fifo.sv
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("sample_fifo depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic full_reg;
  logic empty_reg;
  logic push;
  logic pop;
  logic [AW:0] count_next;

  assign push = in_valid && !full_reg;
  assign pop = out_ready && !empty_reg;
  assign in_ready = !full_reg;
  assign out_valid = !empty_reg;
  assign out_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      count_reg <= count_next;
      full_reg <= (count_next == (AW+1)'(DEPTH));
      empty_reg <= (count_next == '0);
    end
  end
endmodule
